// file: rtl/cbs_pkg.sv
// shared constants for the bus cycle and interrupt sequencer
package cbs_pkg;
	// cycle-type status codes (bit2,bit1,bit0)
	localparam logic [2:0] CT_INTERRUPT_ACK_STROBE_N = 3'h0;
	localparam logic [2:0] CT_IORD = 3'h1;
	localparam logic [2:0] CT_IOWR = 3'h2;
	localparam logic [2:0] CT_HALT = 3'h3;
	localparam logic [2:0] CT_FETCH = 3'h4;
	localparam logic [2:0] CT_MEMRD = 3'h5;
	localparam logic [2:0] CT_MEMWR = 3'h6;
	localparam logic [2:0] CT_PASSIVE = 3'h7;
	// segment indicator codes (high,low)
	localparam logic [1:0] SEG_EXTRA = 2'h0;
	localparam logic [1:0] SEG_STACK = 2'h1;
	localparam logic [1:0] SEG_CODE = 2'h2;
	localparam logic [1:0] SEG_DATA = 2'h3;
	// addresses
	localparam logic [19:0] RESET_VECTOR = 20'hffff0;
	localparam logic [19:0] VECTOR_TABLE_BASE = 20'h00000;
	localparam logic [19:0] VECTOR_TABLE_LAST = 20'h003ff;
	localparam logic [7:0] NMI_TYPE = 8'h02;
	// timing counts in clocks
	localparam int RESET_SEQ_CLOCKS = 10;
	localparam int NMI_MIN_CLOCKS = 2;
	// bus cycle states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_T1 = 6'h02,
		ST_T2 = 6'h04,
		ST_T3 = 6'h08,
		ST_TW = 6'h10,
		ST_T4 = 6'h20
	} cbs_state_e;
endpackage : cbs_pkg

// file: rtl/cbs_reset_seq.sv
// internal reset sequence counter started by the falling reset edge
`timescale 1ns/10ps
module cbs_reset_seq
	import cbs_pkg::*;
#(
	parameter int SEQ_CLOCKS = RESET_SEQ_CLOCKS
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// status
	output logic busy
);
	logic [4:0] cnt_q;

	// counts down after release; the bus stays quiet meanwhile
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 5'(SEQ_CLOCKS);
		end else if (cnt_q != 5'h00) begin
			cnt_q <= cnt_q - 5'h01;
		end
	end

	assign busy = (cnt_q != 5'h00);
endmodule : cbs_reset_seq

// file: rtl/cbs_nmi_detect.sv
// nonmaskable request synchroniser and rising edge latch
`timescale 1ns/10ps
module cbs_nmi_detect
	import cbs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// request and service
	input wire logic nmi_req,
	input wire logic taken,
	output logic pending
);
	logic s1_q, s2_q, s3_q, pend_q;

	// two flops synchronise, the third gives the edge
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else begin
			s1_q <= nmi_req;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// a new edge wins over the service clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pend_q <= 1'b0;
		end else if (s2_q && !s3_q) begin
			pend_q <= 1'b1;
		end else if (taken) begin
			pend_q <= 1'b0;
		end
	end

	assign pending = pend_q;
endmodule : cbs_nmi_detect

// file: rtl/cbs_sequencer.sv
// bus cycle, interrupt acknowledge and halt sequencer
// Behaviour
// RULE_01 - every bus cycle runs T1, T2, T3, T4 in order, at least four clocks
// RULE_02 - address in T1, T2 turns bus on reads, data in T3 and T4
// RULE_03 - wait states between T3 and T4 while ready is low
// RULE_04 - idle states between cycles when no transfer is requested
// RULE_05 - address latch strobe pulses high in T1
// RULE_06 - maximum mode drives three-bit cycle-type status codes
// RULE_07 - upper lines carry A19..A16 in T1, status in T2..T4, with IE flag
// RULE_08 - segment indicator pair encodes segment register used
// RULE_09 - I/O cycles hold upper four address bits low
// RULE_10 - reset must be held high more than four clocks
// RULE_11 - reset aborts at once; ten-clock sequence then fetch from FFFF0H
// RULE_12 - vector table of 256 four-byte pointers at 00000H to 003FFH
// RULE_13 - nonmaskable request beats maskable request
// RULE_14 - nonmaskable pulse lasts at least two clocks
// RULE_15 - interrupts serviced only at instruction or string-iteration boundaries
// RULE_16 - maskable request held until acknowledged
// RULE_17 - flags pushed then interrupt enable cleared on any interrupt
// RULE_18 - lock asserted from T2 of first ack cycle to T2 of second
// RULE_19 - second ack cycle reads type byte, times four gives pointer address
// RULE_20 - halt held until interrupt request or reset
// RULE_21 - memory/IO select valid T1 through T4 in minimum mode
// RULE_22 - read, write, ack strobes active start of T2 to start of T4
// RULE_23 - ready input is active high from the accessed device
// RULE_24 - mode select strapped high for minimum, low for maximum
// RULE_25 - mode-dependent pins switch between strobes and encoded status
`timescale 1ns/10ps
module cbs_sequencer
	import cbs_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// system straps and handshakes
	input wire logic min_max_select,
	input wire logic ready,
	input wire logic maskable_request,
	input wire logic nmi_req,
	// execution side request port
	input wire logic req_valid,
	input wire logic [2:0] req_type,
	input wire logic [19:0] req_addr,
	input wire logic [1:0] req_segment,
	input wire logic [7:0] req_wdata,
	input wire logic instr_boundary,
	input wire logic halt_cmd,
	input wire logic ie_set,
	input wire logic ie_clear,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_rdata,
	output logic irq_take,
	output logic [19:0] irq_vector_addr,
	output logic start_fetch,
	output logic [19:0] start_addr,
	output logic halted,
	output logic ie_flag,
	// bus pins
	output logic [7:0] ad_out,
	output logic ad_oe,
	input wire logic [7:0] ad_in,
	output logic [7:0] addr_mid,
	output logic [3:0] upper_address_status_lines,
	output logic ale,
	// minimum mode strobes
	output logic read_strobe_n,
	output logic write_strobe_n,
	output logic interrupt_ack_strobe_n,
	output logic io_mem_select,
	output logic dir_transmit,
	output logic data_enable_n,
	// maximum mode status
	output logic cycle_type_bit0,
	output logic cycle_type_bit1,
	output logic cycle_type_bit2,
	output logic lock_n,
	output logic [1:0] queue_status
);
	cbs_state_e st_q, st_d;
	logic [2:0] type_q;
	logic [19:0] addr_q;
	logic [1:0] seg_q;
	logic [7:0] wdata_q;
	logic [7:0] rdata_q;
	logic rsp_q;
	logic ie_q;
	logic halt_q;
	logic mode_min_q;
	logic ack_second_q;
	logic ack_nmi_q;
	logic ack_run_q;
	logic lock_q;
	logic take_q;
	logic [19:0] vec_q;
	logic fetch_q;
	logic busy_prev_q;
	logic seq_busy;
	logic nmi_pend;
	logic int_fire;
	logic int_nmi;
	logic ack_start;
	logic ack_done;
	logic bus_go;
	logic in_t1;
	logic is_read;
	logic is_write;
	logic is_io;
	logic is_ack;

	cbs_reset_seq u_rseq (
		.clk(clk),
		.rst(rst),
		.busy(seq_busy)
	);

	cbs_nmi_detect u_nmi (
		.clk(clk),
		.rst(rst),
		.nmi_req(nmi_req),
		.taken(take_q && ack_nmi_q),
		.pending(nmi_pend)
	);

	// boundaries only, nonmaskable first; none in the take clock, so the enable clear lands
	assign int_fire = instr_boundary && !ack_run_q && !seq_busy && !take_q
		&& (nmi_pend || (maskable_request && ie_q)); // see RULE_15
	assign int_nmi = nmi_pend; // see RULE_13
	assign ack_start = int_fire && !int_nmi && st_q == ST_IDLE;
	assign bus_go = !seq_busy && !halt_q && (ack_run_q || req_valid);
	assign req_ready = (st_q == ST_IDLE) && !seq_busy && !halt_q && !ack_run_q && !int_fire;
	assign is_ack = type_q == CT_INTERRUPT_ACK_STROBE_N;
	assign is_io = type_q == CT_IORD || type_q == CT_IOWR;
	assign is_write = type_q == CT_IOWR || type_q == CT_MEMWR;
	assign is_read = !is_write && type_q != CT_HALT;
	assign in_t1 = st_q == ST_T1;
	assign ack_done = is_ack && ack_second_q && st_q == ST_T4;

	// bus state sequence; no shortcut past any T state
	always_comb begin
		st_d = st_q;
		unique case (st_q)
			ST_IDLE: begin
				if ((bus_go && req_ready) || ack_start || (ack_run_q && !seq_busy)) begin
					st_d = ST_T1; // see RULE_01
				end
			end
			ST_T1: st_d = ST_T2;
			ST_T2: st_d = ST_T3;
			ST_T3: st_d = ready ? ST_T4 : ST_TW; // see RULE_03, see RULE_23
			ST_TW: st_d = ready ? ST_T4 : ST_TW;
			ST_T4: st_d = ST_IDLE; // see RULE_04
			default: st_d = ST_IDLE;
		endcase
	end

	// rising reset aborts the cycle at once
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= ST_IDLE; // see RULE_11
		end else begin
			st_q <= st_d;
		end
	end

	// capture cycle attributes at T1 launch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			type_q <= CT_PASSIVE;
			addr_q <= 20'h00000;
			seg_q <= SEG_CODE;
			wdata_q <= 8'h00;
		end else if (st_d == ST_T1 && st_q == ST_IDLE) begin
			if (ack_start || ack_run_q) begin
				type_q <= CT_INTERRUPT_ACK_STROBE_N;
				addr_q <= 20'h00000;
				seg_q <= SEG_CODE;
			end else begin
				type_q <= req_type;
				addr_q <= req_addr;
				seg_q <= req_segment;
				wdata_q <= req_wdata;
			end
		end else if (st_q == ST_T4) begin
			type_q <= CT_PASSIVE;
		end
	end

	// acknowledge pair bookkeeping and lock window
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ack_run_q <= 1'b0;
			ack_second_q <= 1'b0;
			ack_nmi_q <= 1'b0;
			lock_q <= 1'b0;
		end else begin
			if (int_fire && st_q == ST_IDLE) begin
				ack_nmi_q <= int_nmi;
				ack_run_q <= !int_nmi; // nonmaskable skips the bus pair
			end else if (ack_done) begin
				ack_run_q <= 1'b0;
			end
			if (is_ack && st_q == ST_T4) begin
				ack_second_q <= !ack_second_q;
			end
			if (is_ack && st_q == ST_T1 && !ack_second_q) begin
				lock_q <= 1'b1; // see RULE_18
			end else if (is_ack && st_q == ST_T1 && ack_second_q) begin
				lock_q <= 1'b0;
			end
		end
	end

	// read data, type byte and vector address
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= 8'h00;
			rsp_q <= 1'b0;
			take_q <= 1'b0;
			vec_q <= VECTOR_TABLE_BASE;
		end else begin
			rsp_q <= (st_q == ST_T4) && !is_ack; // writes answer too
			take_q <= 1'b0;
			// data taken as T3 or a wait ends; the strobes are gone by T4
			if ((st_q == ST_T3 || st_q == ST_TW) && ready) begin
				rdata_q <= ad_in; // see RULE_02
			end
			if (ack_done) begin
				take_q <= 1'b1;
				vec_q <= VECTOR_TABLE_BASE | {10'h000, rdata_q, 2'b00}; // see RULE_19, see RULE_12
			end else if (int_fire && int_nmi && st_q == ST_IDLE) begin
				take_q <= 1'b1;
				vec_q <= VECTOR_TABLE_BASE | {10'h000, NMI_TYPE, 2'b00};
			end
		end
	end

	// interrupt enable cleared on take; flags are pushed by the caller first
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ie_q <= 1'b0;
		end else if (take_q) begin
			ie_q <= 1'b0; // see RULE_17
		end else if (ie_set) begin
			ie_q <= 1'b1;
		end else if (ie_clear) begin
			ie_q <= 1'b0;
		end
	end

	// halt persists until an interrupt or reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			halt_q <= 1'b0;
		end else if (int_fire || (halt_q && (nmi_pend || (maskable_request && ie_q)))) begin
			halt_q <= 1'b0; // see RULE_20
		end else if (halt_cmd && st_q == ST_IDLE) begin
			halt_q <= 1'b1;
		end
	end

	// mode strap taken while reset sequence runs; reset vector pulse after
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mode_min_q <= 1'b1;
			busy_prev_q <= 1'b1;
			fetch_q <= 1'b0;
		end else begin
			if (seq_busy) begin
				mode_min_q <= min_max_select; // see RULE_24
			end
			busy_prev_q <= seq_busy;
			fetch_q <= busy_prev_q && !seq_busy; // see RULE_11
		end
	end

	assign start_fetch = fetch_q;
	assign start_addr = RESET_VECTOR; // see RULE_11

	// bus pin drive
	always_comb begin
		ad_out = in_t1 ? addr_q[7:0] : wdata_q;
		ad_oe = (in_t1 && !is_ack) || (is_write && st_q != ST_IDLE); // see RULE_02
		addr_mid = addr_q[15:8];
		if (in_t1) begin
			upper_address_status_lines = is_io ? 4'h0 : addr_q[19:16]; // see RULE_09, see RULE_07
		end else begin
			upper_address_status_lines = {1'b0, ie_q, seg_q}; // see RULE_08
		end
	end

	// minimum mode strobes, maximum mode status
	always_comb begin
		logic act;
		logic [2:0] ct;
		act = st_q == ST_T2 || st_q == ST_T3 || st_q == ST_TW; // see RULE_22
		ct = (st_q == ST_T1 || st_q == ST_T2 || act) ? type_q : CT_PASSIVE;
		ale = mode_min_q && in_t1; // see RULE_05
		read_strobe_n = !(mode_min_q && act && is_read && !is_ack);
		write_strobe_n = !(mode_min_q && act && is_write);
		interrupt_ack_strobe_n = !(mode_min_q && act && is_ack);
		io_mem_select = mode_min_q && is_io && st_q != ST_IDLE; // see RULE_21
		dir_transmit = is_write;
		data_enable_n = !(mode_min_q && act);
		cycle_type_bit0 = mode_min_q ? !(is_write) : ct[0]; // see RULE_06, see RULE_25
		cycle_type_bit1 = mode_min_q ? 1'b1 : ct[1];
		cycle_type_bit2 = mode_min_q ? 1'b1 : ct[2];
		lock_n = !(lock_q && (st_q != ST_T1 || ack_second_q));
		queue_status = 2'h0;
	end

	assign rsp_valid = rsp_q;
	assign rsp_rdata = rdata_q;
	assign irq_take = take_q;
	assign irq_vector_addr = vec_q;
	assign halted = halt_q;
	assign ie_flag = ie_q;
endmodule : cbs_sequencer

// file: verification/cbs_seq_asserts.sv
// checker for the sequencer's bus and interrupt ports
`timescale 1ns/10ps
module cbs_seq_asserts
	import cbs_pkg::*;
(
	// watched ports
	input wire logic clk,
	input wire logic rst,
	input wire logic min_max_select,
	input wire logic ready,
	input wire logic req_ready,
	input wire logic irq_take,
	input wire logic [19:0] irq_vector_addr,
	input wire logic ie_flag,
	input wire logic [3:0] upper_address_status_lines,
	input wire logic ale,
	input wire logic read_strobe_n,
	input wire logic io_mem_select,
	input wire logic interrupt_ack_strobe_n,
	input wire logic lock_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// bus cycle shape, minimum mode
	property p_ale; ale |=> !ale; endproperty
	a_ale: assert property (p_ale) else $error("ale too long");
	property p_rd; $fell(read_strobe_n) |-> $past(ale); endproperty
	a_rd: assert property (p_rd) else $error("read strobe not at T2");
	// low ready at T3 or a wait keeps the strobe out
	property p_wt; !read_strobe_n && $past(!read_strobe_n) && !ready |=> !read_strobe_n; endproperty
	a_wt: assert property (p_wt) else $error("no wait state");
	property p_idle; $rose(read_strobe_n) |-> !ale ##1 !ale; endproperty
	a_idle: assert property (p_idle) else $error("no idle state");
	property p_io; ale && io_mem_select && min_max_select |-> upper_address_status_lines == 4'h0;
	endproperty
	a_io: assert property (p_io) else $error("io upper lines");
	property p_iom; ale && min_max_select |=> $stable(io_mem_select) [*3]; endproperty
	a_iom: assert property (p_iom) else $error("io select moved");
	property p_st; !ale && !read_strobe_n |-> upper_address_status_lines[3:2] == {1'b0, ie_flag};
	endproperty
	a_st: assert property (p_st) else $error("status lines");
	property p_vec; irq_take |-> irq_vector_addr[1:0] == 2'h0 && irq_vector_addr <= 20'h003ff;
	endproperty
	a_vec: assert property (p_vec) else $error("vector outside table");
	property p_rst; $fell(rst) |-> !req_ready [*8]; endproperty
	a_rst: assert property (p_rst) else $error("busy too short");
	// lock flips at T2 of each acknowledge cycle
	property p_lock; $fell(interrupt_ack_strobe_n) |-> $changed(lock_n); endproperty
	a_lock: assert property (p_lock) else $error("lock window");
	c_lock: cover property (!lock_n);
	c_wait: cover property (!read_strobe_n && !ready ##1 !read_strobe_n);
	c_take: cover property (irq_take);
	c_io: cover property (ale && io_mem_select);
endmodule : cbs_seq_asserts

bind cbs_sequencer cbs_seq_asserts u_chk (.*);

// file: verification/cbs_mem_model.sv
// memory, port and interrupt controller model on either mode's bus
`timescale 1ns/10ps
module cbs_mem_model
	import cbs_pkg::*;
#(
	parameter logic [7:0] TYPE_BYTE = 8'h21
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus from the sequencer
	input wire logic min_max_select,
	input wire logic ale,
	input wire logic read_strobe_n,
	input wire logic write_strobe_n,
	input wire logic interrupt_ack_strobe_n,
	input wire logic [2:0] status,
	input wire logic [7:0] ad_out,
	input wire logic [3:0] waits,
	// answers
	output logic ready,
	output logic [7:0] ad_in
);
	logic [7:0] addr_q;
	logic [7:0] last_q;
	logic [3:0] cnt_q;
	logic [2:0] status_q;
	logic start;
	logic act;
	logic ack;
	// in maximum mode the controller role decodes status: leaving passive marks T1
	assign start = ale || (!min_max_select && status != CT_PASSIVE && status_q == CT_PASSIVE);
	assign act = min_max_select ? (!read_strobe_n || !write_strobe_n || !interrupt_ack_strobe_n)
		: (status != CT_PASSIVE && status_q != CT_PASSIVE);
	assign ack = min_max_select ? !interrupt_ack_strobe_n : status == CT_INTERRUPT_ACK_STROBE_N;
	// address caught in T1 (ale high, or status leaving passive), wait count restarts each cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			addr_q <= 8'h00;
			cnt_q <= 4'h0;
			last_q <= 8'h00;
			status_q <= CT_PASSIVE;
		end else begin
			last_q <= ad_in;
			status_q <= status;
			if (start) begin
				addr_q <= ad_out;
				cnt_q <= 4'h0;
			end else if (act) begin
				cnt_q <= cnt_q + 4'h1;
			end
		end
	end
	// ready withheld until the wanted waits are spent
	assign ready = act && (cnt_q > waits);
	// idle bus toggles so stale data never looks valid
	assign ad_in = !act ? ~last_q : ack ? TYPE_BYTE : addr_q ^ 8'h5a;
endmodule : cbs_mem_model

// file: verification/tb.sv
// bench for the bus cycle and interrupt sequencer
`timescale 1ns/10ps
module tb;
	import cbs_pkg::*;
	localparam logic [7:0] TB_TYPE = 8'h21;
	logic clk, rst, min_max_select, ready, maskable_request, nmi_req, req_valid, instr_boundary;
	logic halt_cmd, ie_set, ie_clear, req_ready, rsp_valid, irq_take, halted, ie_flag, ale;
	logic read_strobe_n, write_strobe_n, interrupt_ack_strobe_n, io_mem_select;
	logic start_fetch, cycle_type_bit0, cycle_type_bit1, cycle_type_bit2;
	logic [2:0] req_type;
	logic [19:0] req_addr, irq_vector_addr, start_addr;
	logic [1:0] req_segment;
	logic [7:0] req_wdata, rsp_rdata, ad_out, ad_in;
	logic [3:0] upper_address_status_lines, waits;
	int fails, n_tests;
	cbs_sequencer uut (.clk, .rst, .min_max_select, .ready, .maskable_request, .nmi_req,
		.req_valid, .req_type, .req_addr, .req_segment, .req_wdata, .instr_boundary, .halt_cmd,
		.ie_set, .ie_clear, .req_ready, .rsp_valid, .rsp_rdata, .irq_take, .irq_vector_addr,
		.start_fetch, .start_addr, .halted, .ie_flag, .ad_out, .ad_oe(), .ad_in, .addr_mid(),
		.upper_address_status_lines, .ale, .read_strobe_n, .write_strobe_n,
		.interrupt_ack_strobe_n, .io_mem_select, .dir_transmit(), .data_enable_n(),
		.cycle_type_bit0, .cycle_type_bit1, .cycle_type_bit2, .lock_n(), .queue_status());
	cbs_mem_model #(.TYPE_BYTE(TB_TYPE)) fm (.clk, .rst, .min_max_select, .ale, .read_strobe_n,
		.write_strobe_n, .interrupt_ack_strobe_n,
		.status({cycle_type_bit2, cycle_type_bit1, cycle_type_bit0}),
		.ad_out, .waits, .ready, .ad_in);
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// inputs move 2 ns after the edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : tick
	task automatic t_reset;
		int n;
		for (n = 0; n < 20 && req_ready !== 1'b1; n++) tick(1);
		chk("busy clocks", 20'(RESET_SEQ_CLOCKS), 20'(n));
		if (n == 20) tally_and_finish();
		chk("fetch early", 20'h0, 20'(start_fetch));
		tick(1);
		chk("fetch strobe", 20'h1, 20'(start_fetch));
		chk("start address", RESET_VECTOR, start_addr);
		$display("done reset");
	endtask : t_reset
	// one transfer; latency counted from the taking edge
	task automatic xfer(input logic [2:0] t, input logic [19:0] a, input logic [3:0] w);
		int n;
		logic [7:0] wd;
		logic [2:0] ct;
		waits = w;
		req_type = t;
		req_addr = a;
		req_segment = a[1:0];
		req_wdata = a[7:0] ^ 8'h3c;
		wd = 8'h00;
		for (n = 0; n < 40 && req_ready !== 1'b1; n++) tick(1);
		if (n == 40) begin
			fails++;
			tally_and_finish();
		end
		req_valid = 1'b1;
		tick(1);
		req_valid = 1'b0;
		ct = {cycle_type_bit2, cycle_type_bit1, cycle_type_bit0};
		chk("ale in T1", 20'(min_max_select), 20'(ale));
		if (!min_max_select) chk("cycle type", 20'(t), 20'(ct));
		for (n = 1; n < 40 && rsp_valid !== 1'b1; n++) begin
			if (!write_strobe_n || !min_max_select) wd = ad_out;
			tick(1);
		end
		if (n == 40) begin
			fails++;
			tally_and_finish();
		end else begin
			chk("latency", 20'(5 + w), 20'(n));
			if (t == CT_MEMWR || t == CT_IOWR) chk("write data", 20'(a[7:0] ^ 8'h3c), 20'(wd));
			else chk("read data", 20'(a[7:0] ^ 8'h5a), 20'(rsp_rdata));
		end
		$display("done transfer %h", t);
	endtask : xfer
	task automatic wait_take(input logic [19:0] exp);
		int n;
		for (n = 0; n < 60 && irq_take !== 1'b1; n++) tick(1);
		if (n == 60) begin
			fails++;
			tally_and_finish();
		end else begin
			chk("vector address", exp, irq_vector_addr);
			tick(2);
			chk("enable after take", 20'h0, 20'(ie_flag));
		end
	endtask : wait_take
	// both requests pending off a boundary, then taken at one boundary, nonmaskable first and maskable after
	task automatic t_maskable_request;
		logic seen;
		seen = 1'b0;
		instr_boundary = 1'b0;
		ie_set = 1'b1;
		tick(1);
		ie_set = 1'b0;
		maskable_request = 1'b1;
		nmi_req = 1'b1;
		repeat (6) begin
			tick(1);
			seen = seen | irq_take;
		end
		chk("take off boundary", 20'h0, 20'(seen));
		instr_boundary = 1'b1;
		wait_take(20'(NMI_TYPE) << 2);
		nmi_req = 1'b0;
		ie_set = 1'b1;
		tick(1);
		ie_set = 1'b0;
		wait_take(20'(TB_TYPE) << 2);
		maskable_request = 1'b0;
		$display("done interrupts");
	endtask : t_maskable_request
	task automatic t_halt;
		halt_cmd = 1'b1;
		tick(1);
		halt_cmd = 1'b0;
		tick(3);
		chk("halted", 20'h1, 20'(halted));
		chk("refused in halt", 20'h0, 20'(req_ready));
		ie_set = 1'b1;
		tick(1);
		ie_set = 1'b0;
		maskable_request = 1'b1;
		wait_take(20'(TB_TYPE) << 2);
		maskable_request = 1'b0;
		chk("halt left", 20'h0, 20'(halted));
		$display("done halt");
	endtask : t_halt
	// reset again in mid-run with the strap low: encoded status, no strobes
	task automatic t_maxmode;
		rst = 1'b1;
		min_max_select = 1'b0;
		tick(8);
		rst = 1'b0;
		t_reset();
		xfer(CT_MEMRD, 20'h5a5a5, 4'h1);
		xfer(CT_IOWR, 20'h0c3c3, 4'h0);
		$display("done maximum mode");
	endtask : t_maxmode
	initial begin
		{min_max_select, rst} = 2'h3;
		{maskable_request, nmi_req, req_valid, instr_boundary, halt_cmd, ie_set, ie_clear} = 7'h0;
		{req_type, req_addr, req_segment, req_wdata, waits} = '0;
		fails = 0;
		n_tests = 0;
		tick(8);
		rst = 1'b0;
		t_reset();
		xfer(CT_FETCH, 20'hffff0, 4'h0);
		xfer(CT_MEMRD, 20'h12345, 4'h2);
		xfer(CT_IORD, 20'hf00a5, 4'h1);
		xfer(CT_MEMWR, 20'h0abcd, 4'h0);
		xfer(CT_IOWR, 20'hf1234, 4'h3);
		t_maskable_request();
		t_halt();
		t_maxmode();
		tally_and_finish();
	end
endmodule : tb
